// ---- logic/rcl_params.svh ----
// Offsets, field positions, reset values and timing counts for the
// resonant cycle limit and second-output falling-edge offset block.
// Assumes inclusion by its bare name from the top module and the testbench.
`ifndef RCL_PARAMS_SVH
`define RCL_PARAMS_SVH

// Register offsets on the plain register port (byte offsets)
`define RCL_MIN_CYC_HI_OFS  8'h46
`define RCL_FALL_OFS_OFS    8'h47
`define RCL_MIN_CYC_LO_OFS  8'h48
`define RCL_STATUS_OFS      8'h4f

// Field positions of the companion register: low nibble of the limit
`define RCL_LO_NIB_MSB      7
`define RCL_LO_NIB_LSB      4

// Status register bit positions
`define RCL_STAT_CLAMP_BIT  0
`define RCL_STAT_DRIVE_BIT  1
`define RCL_STAT_RUN_BIT    2

// Reset values
`define RCL_MIN_CYC_HI_RST  8'h00
`define RCL_FALL_OFS_RST    8'h00
`define RCL_MIN_CYC_LO_RST  8'h00

// Timing: one limit or offset step is 5 ns, the clock period is 5 ns
`define RCL_STEP_NS         5
`define RCL_CLK_NS          5
`define RCL_CLKS_PER_STEP   ((`RCL_STEP_NS + `RCL_CLK_NS - 1) / `RCL_CLK_NS)

// Shortest period the counter can run, in steps, whatever is programmed
`define RCL_PERIOD_FLOOR    12'h002

`endif

// ---- logic/rcl_pkg.sv ----
// Types shared by the resonant cycle limit block.
// Assumes the constants header sits beside it.
package rcl_pkg;
  // Cycle sequencer states
  typedef enum logic {
    RCL_IDLE,
    RCL_RUN
  } rcl_state_type;

  // A 12-bit switching period or limit, in 5 ns steps
  typedef logic [11:0] rcl_cycle_type;

  // Edge position with sign room for the offset arithmetic
  typedef logic signed [13:0] rcl_pos_type;
endpackage : rcl_pkg

// ---- logic/rcl_top.sv ----
// Resonant cycle generator: minimum cycle clamp and second-output fall edge.
// Assumes a synchronous register master on the plain port, and a control
// loop that supplies the wanted period; all inputs synchronous to clk_sys.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`include "rcl_params.svh"

module rcl_top
  import rcl_pkg::*;
(
  input  wire logic        clk_sys,              // 200 MHz system clock
  input  wire logic        rst,                  // Synchronous, active high
  input  wire logic [7:0]  reg_addr,             // Register offset
  input  wire logic [7:0]  reg_wdata,            // Write data
  input  wire logic        reg_wr,               // Write strobe
  input  wire logic        reg_rd,               // Read strobe
  output logic      [7:0]  reg_rdata,            // Read data, cycle after strobe
  input  wire logic        resonant_en,          // Resonant operation enable
  input  wire logic [11:0] period_req,           // Wanted period in 5 ns steps
  output logic             bridge_output_second, // Second bridge output drive
  output logic             cycle_midpoint_ref,   // Pulse at cycle midpoint
  output logic             cycle_start,          // Pulse at cycle start
  output logic      [11:0] period_active         // Period in use this cycle
);

  // Software registers
  logic [7:0]    min_cycle_limit_high_r, min_cycle_limit_high_nxt; // Limit upper bits
  logic [7:0]    bridge_output_second_fall_offset_r,     bridge_output_second_fall_offset_nxt;     // Signed edge offset
  logic [7:0]    min_cycle_limit_low_r,  min_cycle_limit_low_nxt;  // Companion register
  logic [7:0]    rdata_r,                rdata_nxt;                // Read data stage

  // Step prescaler and cycle sequencer
  logic [3:0]    pre_r,                  pre_nxt;                  // Clocks per step
  logic          step_en;                                          // One-cycle step enable
  rcl_state_type state_r,                state_nxt;                // Sequencer state
  rcl_cycle_type cnt_r,                  cnt_nxt;                  // Step within cycle
  rcl_cycle_type per_r,                  per_nxt;                  // Latched period
  rcl_cycle_type fall_r,                 fall_nxt;                 // Latched fall step
  rcl_cycle_type mid_r,                  mid_nxt;                  // Latched midpoint step
  logic          clamp_r,                clamp_nxt;                // Limit is in force
  logic          drive_r,                drive_nxt;                // Output flop
  logic          midp_r,                 midp_nxt;                 // Midpoint pulse flop
  logic          start_r,                start_nxt;                // Start pulse flop

  // Settings computed from the registers for the next cycle
  rcl_cycle_type min_cycle;                                        // Full 12-bit limit
  rcl_cycle_type per_calc;                                         // Clamped period
  rcl_cycle_type mid_calc;                                         // Midpoint of it
  rcl_cycle_type fall_calc;                                        // Fall step of it
  rcl_pos_type   fall_pos;                                         // Unclamped fall step
  logic          clamp_calc;                                       // Clamp would act
  logic          cyc_end;                                          // Last step of cycle

  // Register file next state: writes land at the mapped offsets
  always_comb begin
    min_cycle_limit_high_nxt = min_cycle_limit_high_r;
    bridge_output_second_fall_offset_nxt     = bridge_output_second_fall_offset_r;
    min_cycle_limit_low_nxt  = min_cycle_limit_low_r;
    if (reg_wr) begin
      unique case (reg_addr)
        `RCL_MIN_CYC_HI_OFS: begin
          min_cycle_limit_high_nxt = reg_wdata;
        end
        `RCL_FALL_OFS_OFS: begin
          bridge_output_second_fall_offset_nxt = reg_wdata;
        end
        `RCL_MIN_CYC_LO_OFS: begin
          // Reserved low nibble is stored too, so it reads back as written
          min_cycle_limit_low_nxt = reg_wdata;
        end
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
  end

  // Read data: valid only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `RCL_MIN_CYC_HI_OFS: rdata_nxt = min_cycle_limit_high_r;
        `RCL_FALL_OFS_OFS:   rdata_nxt = bridge_output_second_fall_offset_r;
        `RCL_MIN_CYC_LO_OFS: rdata_nxt = min_cycle_limit_low_r;
        `RCL_STATUS_OFS: begin
          // Live state of the sequencer, not stored settings
          rdata_nxt[`RCL_STAT_CLAMP_BIT] = clamp_r;
          rdata_nxt[`RCL_STAT_DRIVE_BIT] = drive_r;
          rdata_nxt[`RCL_STAT_RUN_BIT]   = (state_r == RCL_RUN);
        end
        default: rdata_nxt = 8'h00; // Unmapped reads return zero
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      min_cycle_limit_high_r <= `RCL_MIN_CYC_HI_RST;
      bridge_output_second_fall_offset_r     <= `RCL_FALL_OFS_RST;
      min_cycle_limit_low_r  <= `RCL_MIN_CYC_LO_RST;
      rdata_r                <= 8'h00;
    end else begin
      min_cycle_limit_high_r <= min_cycle_limit_high_nxt;
      bridge_output_second_fall_offset_r     <= bridge_output_second_fall_offset_nxt;
      min_cycle_limit_low_r  <= min_cycle_limit_low_nxt;
      rdata_r                <= rdata_nxt;
    end
  end

  // Settings for the coming cycle, from the registers as they stand now
  always_comb begin
    // Upper eight bits joined with the companion nibble
    min_cycle = {min_cycle_limit_high_r,
                 min_cycle_limit_low_r[`RCL_LO_NIB_MSB:`RCL_LO_NIB_LSB]};
    // One count is one 5 ns step, so the period is count times 5 ns
    clamp_calc = (period_req < min_cycle);
    per_calc   = clamp_calc ? min_cycle : period_req;
    // Guard against a zero or one-step period, which has no midpoint
    if (per_calc < `RCL_PERIOD_FLOOR) begin
      per_calc = `RCL_PERIOD_FLOOR;
    end
    mid_calc = {1'b0, per_calc[11:1]};
    // The code is two's complement: 0x80 gives -128 steps, 0xff gives -1
    fall_pos = $signed({2'b00, mid_calc})
             + rcl_pos_type'($signed(bridge_output_second_fall_offset_r));
    // An edge pushed outside the cycle is held at its boundary
    if (fall_pos < 14'sh0000) begin
      fall_calc = 12'h000;
    end else if (fall_pos > $signed({2'b00, per_calc})) begin
      fall_calc = per_calc;
    end else begin
      fall_calc = fall_pos[11:0];
    end
  end

  // Step prescaler: one step enable every five nanoseconds of time
  always_comb begin
    step_en = (pre_r == 4'(`RCL_CLKS_PER_STEP - 1));
    pre_nxt = step_en ? 4'h0 : pre_r + 4'h1;
  end

  // Sequencer next state; settings are latched only at a cycle boundary
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    per_nxt   = per_r;
    mid_nxt   = mid_r;
    fall_nxt  = fall_r;
    clamp_nxt = clamp_r;
    drive_nxt = drive_r;
    midp_nxt  = 1'b0;
    start_nxt = 1'b0;
    cyc_end   = (cnt_r == per_r - 12'h001);
    unique case (state_r)
      RCL_IDLE: begin
        // Output held low until resonant operation is enabled
        drive_nxt = 1'b0;
        if (resonant_en && step_en) begin
          state_nxt = RCL_RUN;
          cnt_nxt   = 12'h000;
          per_nxt   = per_calc;
          mid_nxt   = mid_calc;
          fall_nxt  = fall_calc;
          clamp_nxt = clamp_calc;
          start_nxt = 1'b1;
          drive_nxt = (fall_calc != 12'h000);
        end
      end
      RCL_RUN: begin
        if (step_en) begin
          if (cyc_end) begin
            // A cycle in progress always finishes before stopping, so
            // disabling never truncates the last pulse
            if (resonant_en) begin
              cnt_nxt   = 12'h000;
              per_nxt   = per_calc;
              mid_nxt   = mid_calc;
              fall_nxt  = fall_calc;
              clamp_nxt = clamp_calc;
              start_nxt = 1'b1;
              drive_nxt = (fall_calc != 12'h000);
            end else begin
              state_nxt = RCL_IDLE;
              cnt_nxt   = 12'h000;
              drive_nxt = 1'b0;
            end
          end else begin
            cnt_nxt   = cnt_r + 12'h001;
            // Output stays high until the latched fall step is reached
            drive_nxt = (cnt_nxt < fall_r);
            midp_nxt = (cnt_nxt == mid_r);
          end
        end
      end
    endcase
  end

  // Sequencer flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pre_r   <= 4'h0;
      state_r <= RCL_IDLE;
      cnt_r   <= 12'h000;
      per_r   <= `RCL_PERIOD_FLOOR;
      mid_r   <= 12'h001;
      fall_r  <= 12'h001;
      clamp_r <= 1'b0;
      drive_r <= 1'b0;
      midp_r  <= 1'b0;
      start_r <= 1'b0;
    end else begin
      pre_r   <= pre_nxt;
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      per_r   <= per_nxt;
      mid_r   <= mid_nxt;
      fall_r  <= fall_nxt;
      clamp_r <= clamp_nxt;
      drive_r <= drive_nxt;
      midp_r  <= midp_nxt;
      start_r <= start_nxt;
    end
  end

  // Outputs straight from flops
  assign reg_rdata            = rdata_r;
  assign bridge_output_second = drive_r;
  assign cycle_midpoint_ref   = midp_r;
  assign cycle_start          = start_r;
  assign period_active        = per_r;

endmodule : rcl_top

// ---- verif/rcl_top_properties.sv ----
// Port-level checks on the resonant cycle generator.
// Assumes one clk_sys domain with synchronous active-high rst.
`timescale 1ns/100ps

module rcl_top_properties
  import rcl_pkg::*;
(
  input wire logic        clk_sys,              // System clock
  input wire logic        rst,                  // Synchronous reset
  input wire logic        reg_rd,               // Read strobe
  input wire logic [7:0]  reg_rdata,            // Read data
  input wire logic [11:0] period_req,           // Wanted period
  input wire logic        bridge_output_second, // Second output
  input wire logic        cycle_midpoint_ref,   // Midpoint pulse
  input wire logic        cycle_start,          // Start pulse
  input wire logic [11:0] period_active         // Period in use
);
  logic [19:0] step_r;   // Clocks since the last start; wide so idle gaps shorter than 1048576 clocks do not wrap
  logic [19:0] step_nxt; // Next step count
  logic        seen_r;   // A cycle has been seen since reset
  logic        seen_nxt; // Next seen flag

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Step counter restarts at each cycle start
  always_comb begin
    step_nxt = cycle_start ? 20'h00001 : step_r + 20'h00001;
    seen_nxt = seen_r | cycle_start;
  end

  // Register the helper state
  always_ff @(posedge clk_sys) begin
    step_r <= rst ? 20'h00000 : step_nxt;
    seen_r <= rst ? 1'b0 : seen_nxt;
  end

  // Output low and no new cycle yet
  sequence s_low_go;
    !bridge_output_second ##1 !cycle_start;
  endsequence

  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_period_floor_min: assert property (cycle_start |-> period_active >= $past(period_req)
    && period_active >= 12'h002) else $error("period below request or floor");
  a_period_hold_cycle: assert property (!cycle_start |-> $stable(period_active))
    else $error("period changed mid cycle");
  a_rise_at_start: assert property ($rose(bridge_output_second) |-> cycle_start)
    else $error("output rose outside cycle start");
  a_low_stays_low: assert property (s_low_go |-> !bridge_output_second)
    else $error("output rose again within cycle");
  a_start_single: assert property (cycle_start |=> !cycle_start)
    else $error("start pulse longer than one cycle");
  a_mid_single: assert property (cycle_midpoint_ref |=> !cycle_midpoint_ref)
    else $error("midpoint pulse longer than one cycle");
  a_mid_step_pos: assert property (cycle_midpoint_ref |-> !cycle_start
    && step_r == {8'h00, period_active >> 1}) else $error("midpoint at wrong step");
  a_cycle_len_min: assert property (cycle_start && seen_r
    |-> step_r >= {8'h00, $past(period_active)}) else $error("cycle shorter than period");
endmodule : rcl_top_properties

bind rcl_top rcl_top_properties u_props (
  .clk_sys(clk_sys), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .period_req(period_req), .bridge_output_second(bridge_output_second),
  .cycle_midpoint_ref(cycle_midpoint_ref), .cycle_start(cycle_start),
  .period_active(period_active));

// ---- verif/rcl_top_tb.sv ----
// Self-checking bench for the resonant cycle generator.
// Assumes the register offsets and reset values of the constants header.
`timescale 1ns/100ps
`include "rcl_params.svh"

module rcl_top_tb;
  import rcl_pkg::*;
  logic        clk_sys = 1'b0; // 200 MHz clock
  logic        rst = 1'b1;     // Reset, high at start
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
  logic        reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        resonant_en = 1'b0;
  logic [11:0] period_req = 12'h000;
  logic        drive_out, mid_ref, cyc_st;
  logic [11:0] per_act;
  int          err_count = 0, checks = 0;

  always #2.5 clk_sys = ~clk_sys;

  rcl_top dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .resonant_en(resonant_en),
    .period_req(period_req), .bridge_output_second(drive_out), .cycle_midpoint_ref(mid_ref),
    .cycle_start(cyc_st), .period_active(per_act));

  task automatic conclude();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Settle just after the edge so outputs are stable
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  // One-cycle write, gap after so strobes never double-assign
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick();
    reg_wr <= 1'b0;
    tick();
  endtask : wr

  // Read; data stands one cycle only, then back to zero
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick();
    reg_rd <= 1'b0;
    chk("rdata", reg_rdata, e);
    tick();
    chk("rdata idle", reg_rdata, 8'h00);
  endtask : rd

  // Measure one whole cycle; optionally rewrite the offset at step 1
  task automatic measure(input logic [7:0] nxt, input bit wm, output int hi,
    output int md, output int ln, output logic [11:0] pa);
    int n;
    hi = 0;
    md = -1;
    ln = 0;
    n = 0;
    while (cyc_st !== 1'b1 && n < 3000) begin
      tick();
      n++;
    end
    pa = per_act;
    do begin
      if (drive_out === 1'b1) hi++;
      if (mid_ref === 1'b1) md = ln;
      if (wm && ln == 1) begin
        reg_addr <= `RCL_FALL_OFS_OFS;
        reg_wdata <= nxt;
        reg_wr <= 1'b1;
      end
      if (ln == 2) reg_wr <= 1'b0;
      tick();
      ln++;
      n++;
    end while (cyc_st !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      err_count++;
      conclude();
    end
  endtask : measure

  task automatic t_regs();
    rd(`RCL_MIN_CYC_HI_OFS, `RCL_MIN_CYC_HI_RST);
    rd(`RCL_FALL_OFS_OFS, `RCL_FALL_OFS_RST);
    wr(`RCL_MIN_CYC_HI_OFS, 8'ha5);
    wr(`RCL_FALL_OFS_OFS, 8'h5a);
    wr(`RCL_MIN_CYC_LO_OFS, 8'h3c);
    wr(8'h50, 8'hff);
    rd(`RCL_MIN_CYC_HI_OFS, 8'ha5);
    rd(`RCL_FALL_OFS_OFS, 8'h5a);
    rd(`RCL_MIN_CYC_LO_OFS, 8'h3c);
    rd(8'h50, 8'h00);
  endtask : t_regs

  // Limit pairs with the companion nibble; low nibble of it unused
  task automatic t_limit();
    logic [7:0]  hv [4] = '{8'h01, 8'h01, 8'h00, 8'h02};
    logic [7:0]  lv [4] = '{8'h90, 8'h9a, 8'h00, 8'h00};
    logic [11:0] rq [4] = '{12'h00a, 12'h028, 12'h000, 12'h01f};
    logic [11:0] ex [4] = '{12'h019, 12'h028, 12'h002, 12'h020};
    int hi, md, ln;
    logic [11:0] pa;
    resonant_en <= 1'b1;
    wr(`RCL_FALL_OFS_OFS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(`RCL_MIN_CYC_HI_OFS, hv[i]);
      wr(`RCL_MIN_CYC_LO_OFS, lv[i]);
      period_req <= rq[i];
      measure(8'h00, 1'b0, hi, md, ln, pa);
      measure(8'h00, 1'b0, hi, md, ln, pa);
      chk("period", pa, ex[i]);
      chk("length", ln, ex[i]);
      chk("fall", hi, ex[i] >> 1);
    end
    // Last cycle is clamped, running, output high in its first step
    rd(`RCL_STATUS_OFS, 8'h07);
  endtask : t_limit

  // Each cycle runs on the code set before it; next code written mid cycle
  task automatic t_offset();
    logic [7:0] cd [7] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hff, 8'h40, 8'hc0};
    int hi, md, ln, s, h7f, h80;
    logic [11:0] pa;
    wr(`RCL_MIN_CYC_HI_OFS, 8'h00);
    wr(`RCL_MIN_CYC_LO_OFS, 8'h00);
    wr(`RCL_FALL_OFS_OFS, cd[0]);
    period_req <= 12'd300;
    measure(8'h00, 1'b0, hi, md, ln, pa);
    for (int i = 0; i < 7; i++) begin
      measure(cd[(i + 1) % 7], 1'b1, hi, md, ln, pa);
      s = cd[i][7] ? int'(cd[i]) - 256 : int'(cd[i]);
      chk("offset fall", hi, 150 + s);
      chk("midpoint", md, 150);
      chk("length", ln, 300);
      // Keep the extreme codes' measured high times for the end checks
      if (cd[i] == 8'h7f) h7f = hi;
      if (cd[i] == 8'h80) h80 = hi;
    end
    // Unclamped, running, output high in the first step of the cycle
    rd(`RCL_STATUS_OFS, 8'h06);
    chk("late max", h7f, 277);
    chk("early max", h80, 22);
  endtask : t_offset

  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    tick();
    t_regs();
    t_limit();
    t_offset();
    conclude();
  end
endmodule : rcl_top_tb
